// ==== bench/host_slot_model.sv ====
// Host side of the slot: strobed transfers and the shared interrupt wire
`timescale 1ns/1ps
module host_slot_model
(
    input  wire logic       mclk,
    input  wire logic       host_irq_out,
    input  wire logic       host_irq_oe_n,
    input  wire logic [7:0] prog_rdata,
    output logic            io_strobe_n,
    output logic            prog_sel_n,
    output logic            rw_n,
    output logic [7:0]      prog_addr,
    output logic [7:0]      prog_wdata,
    output wire logic       host_irq_in
);
    // Pulled up; only the card pulls it low
    assign host_irq_in = host_irq_oe_n ? 1'b1 : host_irq_out;
    initial
    begin
        io_strobe_n = 1'b1;
        prog_sel_n = 1'b1;
        rw_n = 1'b1;
        prog_addr = 8'h00;
        prog_wdata = 8'h00;
    end
    task automatic xfer(input logic io, input logic rd, input logic [7:0] a,
                        input logic [7:0] d);
        @(negedge mclk);
        io_strobe_n = !io;
        prog_sel_n = io;
        rw_n = rd;
        prog_addr = a;
        prog_wdata = d;
        @(negedge mclk);
        io_strobe_n = 1'b1;
        prog_sel_n = 1'b1;
        // Released lines do not keep the old value
        prog_addr = ~a;
        prog_wdata = ~d;
    endtask
endmodule

// ==== bench/serial_card_glue_assertions.sv ====
// Port checker for the serial card glue
`timescale 1ns/1ps
`include "serial_glue_cfg.svh"
module glue_checker
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [3:0] rate_switch,
    input wire logic       ext_baud_clk,
    input wire logic       adapter_tx_clk,
    input wire logic       adapter_rx_clk,
    input wire logic       io_strobe_n,
    input wire logic       rw_n,
    input wire logic       buf_power_en,
    input wire logic       buf_dir_to_host,
    input wire logic       prog_sel_n,
    input wire logic       ram_strap,
    input wire logic       mem_power_en,
    input wire logic       mem_write_en,
    input wire logic       adapter_irq_n,
    input wire logic       prio_in,
    input wire logic       prio_out,
    input wire logic       host_irq_oe_n,
    input wire logic       term_ready,
    input wire logic       carrier_gate_input_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence irq_req;
        prio_in && !adapter_irq_n;
    endsequence
    // Long enough for the two-stage external path to settle
    sequence ext_held;
        (rate_switch == `SW_EXT) [*4];
    endsequence
    buf_on_a: assert property (!io_strobe_n |=> buf_power_en)
        else $error("buffer unpowered during strobe");
    buf_off_a: assert property (io_strobe_n |=> !buf_power_en)
        else $error("buffer powered without strobe");
    dir_follow_a: assert property (
        1 |=> buf_dir_to_host == $past(rw_n))
        else $error("buffer direction wrong");
    irq_fwd_a: assert property (
        irq_req |=> !host_irq_oe_n && !prio_out)
        else $error("request not forwarded");
    irq_drop_a: assert property (
        adapter_irq_n |=> host_irq_oe_n && prio_out == $past(prio_in))
        else $error("chain not released");
    irq_block_a: assert property (
        !prio_in |=> host_irq_oe_n && !prio_out)
        else $error("request passed while blocked");
    mem_pwr_a: assert property (1 |=> mem_power_en
        == ($past(ram_strap) || !$past(prog_sel_n)))
        else $error("memory power wrong");
    mem_we_a: assert property (1 |=> mem_write_en
        == ($past(ram_strap) && !$past(rw_n)))
        else $error("memory write enable wrong");
    carrier_a: assert property (
        1 |=> carrier_gate_input_n == !$past(term_ready))
        else $error("carrier gate wrong");
    clk_pair_a: assert property (
        adapter_tx_clk == adapter_rx_clk)
        else $error("transmit and receive clocks differ");
    ext_route_a: assert property (ext_held |->
        adapter_tx_clk == $past(ext_baud_clk, 2))
        else $error("external clock not routed");
endmodule
bind serial_card_glue glue_checker chk (.mclk, .rst_n, .rate_switch,
    .ext_baud_clk, .adapter_tx_clk, .adapter_rx_clk, .io_strobe_n, .rw_n,
    .buf_power_en, .buf_dir_to_host, .prog_sel_n, .ram_strap, .mem_power_en,
    .mem_write_en, .adapter_irq_n, .prio_in, .prio_out, .host_irq_oe_n,
    .term_ready, .carrier_gate_input_n);

// ==== bench/serial_card_glue_bench.sv ====
// Self-checking bench for the serial card glue
`timescale 1ns/1ps
`include "serial_glue_cfg.svh"
module serial_card_glue_bench;
    logic       mclk, rst_n, ram_strap, adapter_irq_n, prio_in, term_ready;
    logic [3:0] rate_switch;
    logic [3:0] ext_cnt = 4'h0;
    logic       ext_baud_clk;
    logic       adapter_tx_clk, adapter_rx_clk, buf_power_en, buf_dir_to_host;
    logic       io_strobe_n, rw_n, prog_sel_n, mem_power_en, mem_write_en;
    logic       prio_out, host_irq_in, host_irq_out, host_irq_oe_n;
    logic       carrier_gate_input_n, io, rd, ok;
    logic [7:0] prog_addr, prog_wdata, prog_rdata;
    int         n_fail, n_compared, seed, cyc, d;
    serial_card_glue DUT (.mclk, .rst_n, .rate_switch, .ext_baud_clk,
        .adapter_tx_clk, .adapter_rx_clk, .io_strobe_n, .rw_n, .buf_power_en,
        .buf_dir_to_host, .prog_sel_n, .ram_strap, .prog_addr, .prog_wdata,
        .prog_rdata, .mem_power_en, .mem_write_en, .adapter_irq_n, .prio_in,
        .prio_out, .host_irq_in, .host_irq_out, .host_irq_oe_n, .term_ready,
        .carrier_gate_input_n);
    host_slot_model host (.mclk, .host_irq_out, .host_irq_oe_n, .prog_rdata,
        .io_strobe_n, .prog_sel_n, .rw_n, .prog_addr, .prog_wdata,
        .host_irq_in);
    // Connector clock, period of 16 mclk
    always @(negedge mclk) ext_cnt <= ext_cnt + 4'h1;
    assign ext_baud_clk = ext_cnt[3];
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Reference ticks per x16 period, in mclk cycles
    function automatic int exp_cyc(input logic [3:0] c);
        int t;
        case (c)
            4'h6: t = 256;
            4'h7: t = 128;
            4'h8: t = 85;
            4'h9, 4'ha: t = 64;
            4'hb: t = 43;
            4'hc: t = 32;
            `SW_9600: t = 16;
            `SW_19200: t = 8;
            default: t = 0;
        endcase
        return (c == `SW_EXT) ? 16 : t * 1000000 / 12288;
    endfunction
    task automatic span(input logic lvl, inout int n);
        while (adapter_tx_clk === lvl && n < 30000)
        begin
            @(negedge mclk);
            n++;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'b0, 1'b1, a, 8'h00);
        @(negedge mclk);
        check("prog_rdata", prog_rdata, e);
    endtask
    initial
    begin
        seed = 32'hb740;
        rst_n = 1'b0;
        rate_switch = `SW_EXT;
        {ram_strap, adapter_irq_n, prio_in, term_ready} = 4'h6;
        n_fail = 0;
        n_compared = 0;
        repeat (19) @(negedge mclk);
        check("prio_out", prio_out, 1'b1);
        check("irq_oe_n", host_irq_oe_n, 1'b1);
        @(negedge mclk);
        rst_n = 1'b1;
        $display("reset test done");
        // Terminal only drives ready; its parity matches
        repeat (150)
        begin
            {adapter_irq_n, prio_in, term_ready, ram_strap} = $random(seed);
            {io, rd} = $random(seed);
            host.xfer(io, rd, $random(seed), $random(seed));
            check("buf_power_en", buf_power_en, io);
            check("buf_dir", buf_dir_to_host, rd);
            check("mem_power", mem_power_en, ram_strap | !io);
            check("mem_we", mem_write_en, ram_strap & !rd);
            ok = prio_in & !adapter_irq_n;
            check("host_irq", host_irq_in, !ok);
            check("prio", prio_out, prio_in & adapter_irq_n);
            check("carrier", carrier_gate_input_n, !term_ready);
            @(negedge mclk);
            check("buf_off", buf_power_en, 1'b0);
            check("mem_off", mem_power_en, ram_strap);
        end
        $display("slot traffic test done");
        ram_strap = 1'b1;
        host.xfer(1'b0, 1'b0, 8'h00, 8'h5a);
        host.xfer(1'b0, 1'b0, 8'hff, 8'ha5);
        rd_chk(8'h00, 8'h5a);
        rd_chk(8'hff, 8'ha5);
        // Without the strap a write must leave the byte alone
        ram_strap = 1'b0;
        host.xfer(1'b0, 1'b0, 8'h00, 8'h33);
        rd_chk(8'h00, 8'h5a);
        $display("memory test done");
        // Slow codes: restart high, then high for half a period
        for (int c = 0; c < 8; c++)
        begin
            rate_switch = c[3:0];
            repeat (3) @(negedge mclk);
            // Codes below six are too slow; only a 2000-cycle hold is seen
            cyc = (c < 6) ? 28000 : 0;
            span(1'b1, cyc);
            d = (c < 6) ? 30000 : exp_cyc(c[3:0]) / 2;
            ok = cyc > d - 100 && cyc < d + 100;
            cyc = ok ? d : cyc;
            check("high_time", cyc, d);
        end
        for (int c = 8; c < 16; c++)
        begin
            rate_switch = c[3:0];
            repeat (4) @(negedge mclk);
            cyc = 0;
            span(1'b1, cyc);
            span(1'b0, cyc);
            cyc = 0;
            span(1'b1, cyc);
            span(1'b0, cyc);
            d = exp_cyc(c[3:0]);
            // One reference tick of phase slip allowed; connector clock exact
            ok = (c == 15) ? cyc == d : cyc > d - 100 && cyc < d + 100;
            cyc = ok ? d : cyc;
            if (c < 13)
                check("period", cyc, d);
            else
                check("src_period", cyc, d);
        end
        $display("baud test done");
        conclude();
    end
    // Baud periods dominate, some 80000 cycles at worst
    initial
    begin
        #(5 * 95000);
        n_fail++;
        conclude();
    end
endmodule

// ==== design/nibble_mem.sv ====
// One 256 x 4 program memory with registered read data
`timescale 1ns/1ps
`include "serial_glue_cfg.svh"
module nibble_mem
(
    input  wire logic   mclk,
    input  wire logic   rst_n,
    nibble_mem_if.store bus
);
    logic [3:0]                    mem [0:255];
    serial_glue_pkg::nibble_state_s cur_reg;
    serial_glue_pkg::nibble_state_s cur_next;

    always_comb
    begin
        cur_next = cur_reg;
        if (bus.en && !bus.we)
        begin
            cur_next.rd = mem[bus.addr];
        end
    end

    // Array has no reset; contents are undefined until written
    always_ff @(posedge mclk)
    begin
        if (bus.en && bus.we)
        begin
            mem[bus.addr] <= bus.wd;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_reg.rd <= `RST_NIBBLE;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign bus.rd = cur_reg.rd;
endmodule

// ==== design/serial_card_glue.sv ====
// Baud clock generator, slot buffer control and interrupt chain link
`timescale 1ns/1ps
`include "serial_glue_cfg.svh"
// Overview of operation
// - Every internal baud clock divides the 2.4576 MHz reference.
// - Four switch bits give sixteen codes choosing the divisor.
// - Chosen x16 clock drives adapter transmit and receive clocks.
// - Divider alone gives twelve standard rates, 50 to 4800 baud.
// - Two codes both select 2400 baud, filling thirteen codes.
// - Reference prescaled by sixteen gives the 9600 baud x16 clock.
// - One code takes the divide-by-eight tap for 19200 baud.
// - Last code routes the connector clock, up to 50000 baud.
// - Data buffer powered only while the I/O strobe is low.
// - Buffer drives toward host on reads, toward adapter on writes.
// - Priority in high and adapter request low pull host interrupt low.
// - While forwarding, outgoing priority is driven low.
// - Adapter withdrawal releases host interrupt, priority out follows priority in.
// - 256 bytes from two nibble memories, enabled by program strobe.
// - Program memories powered during their select strobe, and always while strapped writable.
// - Writable strap keeps memory powered and passes read/write to it.
// - Terminal-ready low stops adapter transmission, high resumes it.
module serial_card_glue
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  rate_switch,
    input  wire logic        ext_baud_clk,
    output logic             adapter_tx_clk,
    output logic             adapter_rx_clk,
    input  wire logic        io_strobe_n,
    input  wire logic        rw_n,
    output logic             buf_power_en,
    output logic             buf_dir_to_host,
    input  wire logic        prog_sel_n,
    input  wire logic        ram_strap,
    input  wire logic [7:0]  prog_addr,
    input  wire logic [7:0]  prog_wdata,
    output logic [7:0]       prog_rdata,
    output logic             mem_power_en,
    output logic             mem_write_en,
    input  wire logic        adapter_irq_n,
    input  wire logic        prio_in,
    output logic             prio_out,
    input  wire logic        host_irq_in,
    output logic             host_irq_out,
    output logic             host_irq_oe_n,
    input  wire logic        term_ready,
    output logic             carrier_gate_input_n
);
    serial_glue_pkg::glue_state_s cur_reg;
    serial_glue_pkg::glue_state_s cur_next;
    logic                         out_low_reg;

    nibble_mem_if mem_lo ();
    nibble_mem_if mem_hi ();

    // Switch code to source; fixed table
    function automatic serial_glue_pkg::rate_src_e src_of
    (
        input logic [3:0] code
    );
        serial_glue_pkg::rate_src_e s;
        s = serial_glue_pkg::SRC_DIV;
        if (code == `SW_EXT)
        begin
            s = serial_glue_pkg::SRC_EXT;
        end
        else if (code == `SW_19200)
        begin
            s = serial_glue_pkg::SRC_PRE8;
        end
        else if (code == `SW_9600)
        begin
            s = serial_glue_pkg::SRC_PRE16;
        end
        return s;
    endfunction

    // Switch code to full reference divisor
    function automatic logic [11:0] div_of
    (
        input logic [3:0] code
    );
        logic [11:0] d;
        d = `DIV_9600;
        unique case (code)
            4'h0: d = `DIV_50;
            4'h1: d = `DIV_75;
            4'h2: d = `DIV_110;
            4'h3: d = `DIV_134;
            4'h4: d = `DIV_150;
            4'h5: d = `DIV_300;
            4'h6: d = `DIV_600;
            4'h7: d = `DIV_1200;
            4'h8: d = `DIV_1800;
            4'h9: d = `DIV_2400;
            4'ha: d = `DIV_2400;
            4'hb: d = `DIV_3600;
            4'hc: d = `DIV_4800;
            4'hd: d = `DIV_9600;
            4'he: d = `DIV_9600;
            4'hf: d = `DIV_9600;
        endcase
        return d;
    endfunction

    always_comb
    begin
        logic [32:0]                acc;
        logic                       ref_tick;
        logic                       sel_changed;
        logic [11:0]                div;
        logic [11:0]                half;
        logic                       irq_fwd;
        serial_glue_pkg::rate_src_e src;

        acc         = 33'h000000000;
        ref_tick    = 1'b0;
        sel_changed = 1'b0;
        div         = 12'h000;
        half        = 12'h000;
        irq_fwd     = 1'b0;
        src         = serial_glue_pkg::SRC_DIV;
        cur_next    = cur_reg;

        // Fractional step keeps the long-run reference rate within 3 ppb of REF_HZ
        acc = {1'b0, cur_reg.phase} + {1'b0, `REF_PHASE_INC};
        cur_next.phase = acc[31:0];
        ref_tick       = acc[32];

        cur_next.sel = rate_switch;
        sel_changed  = (rate_switch != cur_reg.sel);
        src          = src_of(cur_reg.sel);
        div          = div_of(cur_reg.sel);
        half         = div >> 1;

        if (ref_tick)
        begin
            cur_next.pre_cnt = cur_reg.pre_cnt + 4'h1;
        end

        // Restart on a switch change to avoid a runt period
        if (sel_changed)
        begin
            cur_next.div_cnt = 12'h000;
        end
        else if (ref_tick)
        begin
            if (cur_reg.div_cnt >= div - 12'h001)
            begin
                cur_next.div_cnt = 12'h000;
            end
            else
            begin
                cur_next.div_cnt = cur_reg.div_cnt + 12'h001;
            end
        end

        cur_next.ext_q = ext_baud_clk;

        unique case (src)
            serial_glue_pkg::SRC_DIV:
                cur_next.baud_clk = (cur_reg.div_cnt < half);
            serial_glue_pkg::SRC_PRE16:
                cur_next.baud_clk = cur_reg.pre_cnt[`PRE_TAP_16];
            serial_glue_pkg::SRC_PRE8:
                cur_next.baud_clk = cur_reg.pre_cnt[`PRE_TAP_8];
            serial_glue_pkg::SRC_EXT:
                cur_next.baud_clk = cur_reg.ext_q;
        endcase

        // Slot data buffer
        cur_next.buf_pwr = !io_strobe_n;
        cur_next.buf_dir = rw_n;

        // Program memory power and write pass-through
        cur_next.mem_pwr = ram_strap || !prog_sel_n;
        cur_next.mem_we  = ram_strap && !rw_n;

        // Daisy chain link
        irq_fwd           = prio_in && !adapter_irq_n;
        cur_next.irq_oe_n = !irq_fwd;
        cur_next.prio_out = prio_in && adapter_irq_n;

        // Terminal ready gates the adapter through its carrier input
        cur_next.dcd_n = !term_ready;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_reg.phase    <= 32'h00000000;
            cur_reg.pre_cnt  <= 4'h0;
            cur_reg.div_cnt  <= 12'h000;
            cur_reg.sel      <= `RST_SEL;
            cur_reg.ext_q    <= 1'b0;
            cur_reg.baud_clk <= `RST_BAUD_CLK;
            cur_reg.buf_pwr  <= `RST_BUF_PWR;
            cur_reg.buf_dir  <= `RST_BUF_DIR;
            cur_reg.mem_pwr  <= `RST_MEM_PWR;
            cur_reg.mem_we   <= 1'b0;
            cur_reg.irq_oe_n <= `RST_IRQ_OE_N;
            cur_reg.prio_out <= `RST_PRIO_OUT;
            cur_reg.dcd_n    <= `RST_DCD_N;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    // Open-drain line only ever pulls low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_low_reg <= 1'b0;
        end
        else
        begin
            out_low_reg <= 1'b0;
        end
    end

    // Memory select; host keeps strobes to one transfer each
    assign mem_lo.en   = !prog_sel_n;
    assign mem_lo.we   = ram_strap && !rw_n;
    assign mem_lo.addr = prog_addr;
    assign mem_lo.wd   = prog_wdata[3:0];
    assign mem_hi.en   = !prog_sel_n;
    assign mem_hi.we   = ram_strap && !rw_n;
    assign mem_hi.addr = prog_addr;
    assign mem_hi.wd   = prog_wdata[7:4];

    nibble_mem u_mem_lo
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (mem_lo.store)
    );

    nibble_mem u_mem_hi
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (mem_hi.store)
    );

    assign adapter_tx_clk       = cur_reg.baud_clk;
    assign adapter_rx_clk       = cur_reg.baud_clk;
    assign buf_power_en         = cur_reg.buf_pwr;
    assign buf_dir_to_host      = cur_reg.buf_dir;
    assign prog_rdata           = {mem_hi.rd, mem_lo.rd};
    assign mem_power_en         = cur_reg.mem_pwr;
    assign mem_write_en         = cur_reg.mem_we;
    assign prio_out             = cur_reg.prio_out;
    assign host_irq_out         = out_low_reg;
    assign host_irq_oe_n        = cur_reg.irq_oe_n;
    assign carrier_gate_input_n = cur_reg.dcd_n;
endmodule

// ==== pkg/nibble_mem_if.sv ====
// Carrier between the glue top and one nibble-wide program memory
`timescale 1ns/1ps
interface nibble_mem_if;
    logic       en;
    logic       we;
    logic [7:0] addr;
    logic [3:0] wd;
    logic [3:0] rd;

    modport host
    (
        output en,
        output we,
        output addr,
        output wd,
        input  rd
    );

    modport store
    (
        input  en,
        input  we,
        input  addr,
        input  wd,
        output rd
    );
endinterface

// ==== pkg/serial_glue_cfg.svh ====
// Constants for the serial card baud and slot glue logic
`ifndef SERIAL_GLUE_CFG_SVH
`define SERIAL_GLUE_CFG_SVH

// Clock rates in hertz
`define MCLK_HZ          64'd200000000
`define REF_HZ           64'd2457600
`define REF_PHASE_W      32
// Phase step per mclk cycle for a reference tick at REF_HZ
`define REF_PHASE_INC    32'((`REF_HZ << `REF_PHASE_W) / `MCLK_HZ)

// Switch codes with special sources
`define SW_9600          4'hd
`define SW_19200         4'he
`define SW_EXT           4'hf

// Full divisors of the reference, reference ticks per x16 period
`define DIV_50           12'hc00
`define DIV_75           12'h800
`define DIV_110          12'h574
`define DIV_134          12'h476
`define DIV_150          12'h400
`define DIV_300          12'h200
`define DIV_600          12'h100
`define DIV_1200         12'h080
`define DIV_1800         12'h055
`define DIV_2400         12'h040
`define DIV_3600         12'h02b
`define DIV_4800         12'h020
`define DIV_9600         12'h010

// Prescaler taps: divide by 16 and divide by 8
`define PRE_TAP_16       3
`define PRE_TAP_8        2

// Reset values
`define RST_SEL          4'h0
`define RST_BAUD_CLK     1'b0
`define RST_BUF_PWR      1'b0
`define RST_BUF_DIR      1'b0
`define RST_MEM_PWR      1'b0
`define RST_IRQ_OE_N     1'b1
`define RST_PRIO_OUT     1'b1
`define RST_DCD_N        1'b1
`define RST_NIBBLE       4'h0

`endif

// ==== pkg/serial_glue_pkg.sv ====
// Types shared by the serial card glue modules
package serial_glue_pkg;

    typedef enum logic [1:0] {
        SRC_DIV   = 2'b00,
        SRC_PRE16 = 2'b01,
        SRC_PRE8  = 2'b11,
        SRC_EXT   = 2'b10
    } rate_src_e;

    typedef struct packed {
        logic [31:0] phase;
        logic [3:0]  pre_cnt;
        logic [11:0] div_cnt;
        logic [3:0]  sel;
        logic        ext_q;
        logic        baud_clk;
        logic        buf_pwr;
        logic        buf_dir;
        logic        mem_pwr;
        logic        mem_we;
        logic        irq_oe_n;
        logic        prio_out;
        logic        dcd_n;
    } glue_state_s;

    typedef struct packed {
        logic [3:0] rd;
    } nibble_state_s;

endpackage
